// >>> core/status_register.sv
`timescale 1ns/1ps
module status_register (
    input  wire logic                                hclk,
    input  wire logic                                hresetn,
    input  wire logic                                ce,
    input  wire logic [status_pkg::SECTION_WIDTH-1:0] cond_in,
    input  wire logic                                write_rising,
    input  wire logic                                write_falling,
    input  wire logic                                write_mask,
    input  wire logic [status_pkg::SECTION_WIDTH-1:0] wdata,
    input  wire logic                                read_clear,
    output logic      [status_pkg::SECTION_WIDTH-1:0] cond,
    output logic      [status_pkg::SECTION_WIDTH-1:0] rising_edge_filter,
    output logic      [status_pkg::SECTION_WIDTH-1:0] falling_edge_filter,
    output logic      [status_pkg::SECTION_WIDTH-1:0] event_bits,
    output logic      [status_pkg::SECTION_WIDTH-1:0] mask,
    output logic                                     summary
);
    import status_pkg::*;

    logic [SECTION_WIDTH-1:0] cond_prev;
    logic [SECTION_WIDTH-1:0] edge_hits;

    // ==========
    // Present state and edge filtering.
    assign cond = cond_in & SECTION_VALID_MASK;
    assign edge_hits = (cond & ~cond_prev & rising_edge_filter)
                     | (~cond & cond_prev & falling_edge_filter);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cond_prev <= SECTION_RESET;
        end else if (ce) begin
            cond_prev <= cond;
        end
    end

    // ==========
    // Host writable sections.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rising_edge_filter  <= SECTION_RESET;
            falling_edge_filter <= SECTION_RESET;
            mask                <= SECTION_RESET;
        end else if (ce) begin
            if (write_rising) begin
                rising_edge_filter <= wdata & SECTION_VALID_MASK;
            end
            if (write_falling) begin
                falling_edge_filter <= wdata & SECTION_VALID_MASK;
            end
            if (write_mask) begin
                mask <= wdata & SECTION_VALID_MASK;
            end
        end
    end

    // ==========
    // Latched events.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            event_bits <= SECTION_RESET;
        end else if (ce) begin
            event_bits <= (read_clear ? SECTION_RESET : event_bits)
                        | edge_hits;
        end
    end

    assign summary = |(event_bits & mask);

endmodule

// >>> core/status_reporting_hierarchy.sv
// Notes on behaviour
// - Five 16-bit sections share bit meanings.
// - Bit 15 always reads zero.
// - Operation bit 3 is sweep active.
// - Present state mirrors hardware, read-only.
// - Chained present bit clears on read.
// - Rising edge sets event if rising filter set.
// - Falling edge sets event if falling filter set.
// - Filters and mask are read/write.
// - Events latch passed edges; a read clears them.
// - Summary is OR of event AND mask.
// - Summary feeds the next register up.
// - Each client owns an independent copy.
// - Bit 4 shows message available.
// - Standard event mask enables its register.
// - Bit 6 summarises other bits, not latched.
// - Request mask ignores bit 6.
// - Masked rising bit raises a request.
// - Poll mask gates the individual flag.
// - Flag is OR of status AND poll mask.
// - Bit 2 is set while errors are queued.
//
// Implementation choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
module status_reporting_hierarchy #(
    parameter int NUM_CLIENTS = 2
) (
    input  wire logic                                 hclk,
    input  wire logic                                 hresetn,
    input  wire logic                                 ce,
    input  wire logic                                 hsel,
    input  wire logic [31:0]                          haddr,
    input  wire logic [1:0]                           htrans,
    input  wire logic                                 hwrite,
    input  wire logic [2:0]                           hsize,
    input  wire logic [31:0]                          hwdata,
    input  wire logic                                 hready,
    output logic      [31:0]                          hrdata,
    output logic                                      hreadyout,
    output logic                                      hresp,
    input  wire logic                                 sweep_active,
    input  wire logic [status_pkg::SECTION_WIDTH-1:0] operation_cond,
    input  wire logic [status_pkg::SECTION_WIDTH-1:0] questionable_cond,
    input  wire logic [status_pkg::SECTION_WIDTH-1:0] trace_cond,
    input  wire logic [status_pkg::SECTION_WIDTH-1:0] extension_cond,
    input  wire logic [status_pkg::SECTION_WIDTH-1:0] standard_event_cond,
    input  wire logic [NUM_CLIENTS-1:0]               message_available,
    input  wire logic [NUM_CLIENTS-1:0]               error_queue_not_empty,
    output logic      [NUM_CLIENTS-1:0]               service_request,
    output logic      [NUM_CLIENTS-1:0]               individual_status_flag
);
    import status_pkg::*;

    localparam int W = SECTION_WIDTH;
    localparam int R = NUM_REGS;

    bus_state_type        bus_state;
    logic [7:0]           addr_off;
    logic [CLIENT_W-1:0]  addr_client;
    logic                 accept;
    logic                 write_active;
    logic                 read_active;
    logic [2:0]           addr_reg;
    logic [4:0]           addr_sec;
    logic [31:0]          next_hrdata;

    logic [W-1:0] hw_cond      [NUM_CLIENTS][R];
    logic [W-1:0] cond_q       [NUM_CLIENTS][R];
    logic [W-1:0] rising_q     [NUM_CLIENTS][R];
    logic [W-1:0] falling_q    [NUM_CLIENTS][R];
    logic [W-1:0] event_q      [NUM_CLIENTS][R];
    logic [W-1:0] mask_q       [NUM_CLIENTS][R];
    logic         summary_q    [NUM_CLIENTS][R];
    logic         read_clear_q [NUM_CLIENTS][R];
    logic         wr_rising_q  [NUM_CLIENTS][R];
    logic         wr_falling_q [NUM_CLIENTS][R];
    logic         wr_mask_q    [NUM_CLIENTS][R];

    logic [BYTE_WIDTH-1:0] service_request_mask [NUM_CLIENTS];
    logic [BYTE_WIDTH-1:0] parallel_poll_mask   [NUM_CLIENTS];
    logic [BYTE_WIDTH-1:0] top_status_byte      [NUM_CLIENTS];
    logic [BYTE_WIDTH-1:0] status_prev          [NUM_CLIENTS];
    logic [1:0]            chain_enable         [NUM_CLIENTS];
    logic [1:0]            chain_hold           [NUM_CLIENTS];

    // ==========
    // Bus slave.
    assign accept = hsel & hready & htrans[1] & (hsize == HSIZE_WORD);
    assign write_active = (bus_state == bus_write);
    assign read_active  = (bus_state == bus_read);
    assign addr_reg = addr_off[7:REG_SHIFT];
    assign addr_sec = addr_off[REG_SHIFT-1:0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_state   <= bus_idle;
            addr_off    <= 8'h00;
            addr_client <= '0;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
            hrdata      <= DATA_RESET;
        end else if (ce) begin
            unique case (bus_state)
                bus_idle, bus_write: begin
                    if (accept) begin
                        addr_off    <= haddr[7:0];
                        addr_client <= haddr[CLIENT_SHIFT +: CLIENT_W];
                        bus_state   <= hwrite ? bus_write : bus_read;
                        hreadyout   <= hwrite;
                    end else begin
                        bus_state <= bus_idle;
                    end
                end
                bus_read: begin
                    hrdata    <= next_hrdata;
                    hreadyout <= 1'b1;
                    bus_state <= bus_idle;
                end
            endcase
        end
    end

    // ==========
    // Read data selection.
    always_comb begin
        next_hrdata = DATA_RESET;
        for (int c = 0; c < NUM_CLIENTS; c++) begin
            if (addr_client == CLIENT_W'(c)) begin
                if (addr_off == OFF_STATUS) begin
                    next_hrdata = {24'h000000, top_status_byte[c]};
                end else if (addr_off == OFF_SRQ_MASK) begin
                    next_hrdata = {24'h000000, service_request_mask[c]};
                end else if (addr_off == OFF_POLL_MASK) begin
                    next_hrdata = {24'h000000, parallel_poll_mask[c]};
                end else if (addr_off == OFF_CHAIN) begin
                    next_hrdata = {30'h00000000, chain_enable[c]};
                end
                for (int r = 0; r < R; r++) begin
                    if (addr_reg == 3'(r)) begin
                        unique case (addr_sec)
                            OFF_COND:
                                next_hrdata = {16'h0000, cond_q[c][r]};
                            OFF_RISING:
                                next_hrdata = {16'h0000, rising_q[c][r]};
                            OFF_FALLING:
                                next_hrdata = {16'h0000, falling_q[c][r]};
                            OFF_EVENT:
                                next_hrdata = {16'h0000, event_q[c][r]};
                            OFF_MASK:
                                next_hrdata = {16'h0000, mask_q[c][r]};
                            default: ;
                        endcase
                    end
                end
            end
        end
    end

    // ==========
    // Per client hierarchy.
    generate
        for (genvar c = 0; c < NUM_CLIENTS; c++) begin : g_client
            logic [BYTE_WIDTH-1:0] status_base;
            logic                  master_summary;

            // Present state inputs, with optional summary chaining.
            always_comb begin
                hw_cond[c][REG_OPERATION] = operation_cond;
                hw_cond[c][REG_OPERATION][SWEEP_BIT] = sweep_active;
                if (chain_enable[c][0]) begin
                    hw_cond[c][REG_OPERATION][CHAIN_BIT] =
                        summary_q[c][REG_EXTENSION] & ~chain_hold[c][0];
                end
                hw_cond[c][REG_QUESTIONABLE] = questionable_cond;
                if (chain_enable[c][1]) begin
                    hw_cond[c][REG_QUESTIONABLE][CHAIN_BIT] =
                        summary_q[c][REG_TRACE] & ~chain_hold[c][1];
                end
                hw_cond[c][REG_TRACE]     = trace_cond;
                hw_cond[c][REG_EXTENSION] = extension_cond;
                hw_cond[c][REG_STD_EVENT] = standard_event_cond;
            end

            for (genvar r = 0; r < R; r++) begin : g_reg
                logic hit;
                assign hit = (addr_client == CLIENT_W'(c))
                           & (addr_reg == 3'(r));
                assign wr_rising_q[c][r]  = write_active & hit
                                          & (addr_sec == OFF_RISING);
                assign wr_falling_q[c][r] = write_active & hit
                                          & (addr_sec == OFF_FALLING);
                assign wr_mask_q[c][r]    = write_active & hit
                                          & (addr_sec == OFF_MASK);
                assign read_clear_q[c][r] = read_active & hit
                                          & (addr_sec == OFF_EVENT);

                status_register u_reg (
                    .hclk                (hclk),
                    .hresetn             (hresetn),
                    .ce                  (ce),
                    .cond_in             (hw_cond[c][r]),
                    .write_rising        (wr_rising_q[c][r]),
                    .write_falling       (wr_falling_q[c][r]),
                    .write_mask          (wr_mask_q[c][r]),
                    .wdata               (hwdata[W-1:0]),
                    .read_clear          (read_clear_q[c][r]),
                    .cond                (cond_q[c][r]),
                    .rising_edge_filter  (rising_q[c][r]),
                    .falling_edge_filter (falling_q[c][r]),
                    .event_bits          (event_q[c][r]),
                    .mask                (mask_q[c][r]),
                    .summary             (summary_q[c][r])
                );
            end

            // Status byte assembly.
            always_comb begin
                status_base            = BYTE_RESET;
                status_base[STB_EXT]   = summary_q[c][REG_EXTENSION];
                status_base[STB_TRACE] = summary_q[c][REG_TRACE];
                status_base[STB_ERR]   = error_queue_not_empty[c];
                status_base[STB_QUES]  = summary_q[c][REG_QUESTIONABLE];
                status_base[STB_MAV]   = message_available[c];
                status_base[STB_ESB]   = summary_q[c][REG_STD_EVENT];
                status_base[STB_OPER]  = summary_q[c][REG_OPERATION];
            end
            assign master_summary = |(status_base & service_request_mask[c]
                                      & SRQ_IGNORE_MASK);
            always_comb begin
                top_status_byte[c]          = status_base;
                top_status_byte[c][STB_MSS] = master_summary;
            end
        end
    endgenerate

    // ==========
    // Masks and request outputs.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int c = 0; c < NUM_CLIENTS; c++) begin
                service_request_mask[c] <= BYTE_RESET;
                parallel_poll_mask[c]   <= BYTE_RESET;
                status_prev[c]          <= BYTE_RESET;
                chain_enable[c]         <= CHAIN_RESET;
                chain_hold[c]           <= CHAIN_RESET;
            end
            service_request        <= '0;
            individual_status_flag <= '0;
        end else if (ce) begin
            for (int c = 0; c < NUM_CLIENTS; c++) begin
                if (write_active && addr_client == CLIENT_W'(c)) begin
                    if (addr_off == OFF_SRQ_MASK) begin
                        service_request_mask[c] <= hwdata[7:0];
                    end
                    if (addr_off == OFF_POLL_MASK) begin
                        parallel_poll_mask[c] <= hwdata[7:0];
                    end
                    if (addr_off == OFF_CHAIN) begin
                        chain_enable[c] <= hwdata[1:0];
                    end
                end
                if (!summary_q[c][REG_EXTENSION]) begin
                    chain_hold[c][0] <= 1'b0;
                end else if (read_clear_q[c][REG_OPERATION]) begin
                    chain_hold[c][0] <= 1'b1;
                end
                if (!summary_q[c][REG_TRACE]) begin
                    chain_hold[c][1] <= 1'b0;
                end else if (read_clear_q[c][REG_QUESTIONABLE]) begin
                    chain_hold[c][1] <= 1'b1;
                end
                status_prev[c] <= top_status_byte[c];
                service_request[c] <= |(top_status_byte[c]
                    & ~status_prev[c] & service_request_mask[c]
                    & SRQ_IGNORE_MASK);
                individual_status_flag[c] <= |(top_status_byte[c]
                    & parallel_poll_mask[c]);
            end
        end
    end

endmodule

// >>> pkg/status_pkg.sv
package status_pkg;

    // ==========
    // Section layout.
    localparam int SECTION_WIDTH = 16;
    localparam int TOP_BIT       = 15;
    localparam int SWEEP_BIT     = 3;
    localparam int CHAIN_BIT     = 14;
    localparam int NUM_REGS      = 5;
    localparam int BYTE_WIDTH    = 8;
    localparam logic [15:0] SECTION_RESET      = 16'h0000;
    localparam logic [15:0] SECTION_VALID_MASK = 16'h7FFF;
    localparam logic [7:0]  BYTE_RESET         = 8'h00;
    localparam logic [1:0]  CHAIN_RESET        = 2'h0;

    // ==========
    // Register indices.
    localparam logic [2:0] REG_OPERATION    = 3'h0;
    localparam logic [2:0] REG_QUESTIONABLE = 3'h1;
    localparam logic [2:0] REG_TRACE        = 3'h2;
    localparam logic [2:0] REG_EXTENSION    = 3'h3;
    localparam logic [2:0] REG_STD_EVENT    = 3'h4;

    // ==========
    // Byte offsets.
    localparam int          CLIENT_SHIFT = 8;
    localparam int          CLIENT_W     = 4;
    localparam int          REG_SHIFT    = 5;
    localparam logic [4:0] OFF_COND      = 5'h00;
    localparam logic [4:0] OFF_RISING    = 5'h04;
    localparam logic [4:0] OFF_FALLING   = 5'h08;
    localparam logic [4:0] OFF_EVENT     = 5'h0C;
    localparam logic [4:0] OFF_MASK      = 5'h10;
    localparam logic [7:0] OFF_STATUS    = 8'hA0;
    localparam logic [7:0] OFF_SRQ_MASK  = 8'hA4;
    localparam logic [7:0] OFF_POLL_MASK = 8'hA8;
    localparam logic [7:0] OFF_CHAIN     = 8'hAC;

    // ==========
    // Status byte bit positions.
    localparam int STB_EXT   = 0;
    localparam int STB_TRACE = 1;
    localparam int STB_ERR   = 2;
    localparam int STB_QUES  = 3;
    localparam int STB_MAV   = 4;
    localparam int STB_ESB   = 5;
    localparam int STB_MSS   = 6;
    localparam int STB_OPER  = 7;
    localparam logic [7:0] SRQ_IGNORE_MASK = 8'hBF;

    // ==========
    // Bus.
    localparam logic [2:0]  HSIZE_WORD = 3'h2;
    localparam logic [31:0] DATA_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {bus_idle, bus_write, bus_read} bus_state_type;

endpackage

// >>> verif/host_bus_model.sv
`timescale 1ns/1ps
// ==========
// Remote host bus master.
module host_bus_model (
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel = 1'b0,
    output logic [31:0]      haddr = 32'h0000_0000,
    output logic [1:0]       htrans = 2'h0,
    output logic             hwrite = 1'b0,
    output logic [2:0]       hsize = 3'h2,
    output logic [31:0]      hwdata = 32'h0000_0000,
    output logic             timed_out = 1'b0
);
    import status_pkg::*;
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hready !== 1'b1 && n < 50) begin
            n++;
            @(posedge hclk);
        end
        if (n >= 50) timed_out = 1'b1;
    endtask
    // Writes or reads one word at any address: sections, status, masks or chain.
    task automatic xfer(input logic wr, input logic [31:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize  <= HSIZE_WORD;
        wait_ready();
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        hwdata <= ~wd;
    endtask
endmodule

// >>> verif/status_reporting_hierarchy_monitor.sv
`timescale 1ns/1ps
// ==========
// Bus and request checks.
module status_reporting_hierarchy_monitor #(
    parameter int NUM_CLIENTS = 2
) (
    input wire logic                   hclk,
    input wire logic                   hresetn,
    input wire logic                   ce,
    input wire logic                   hsel,
    input wire logic [31:0]            haddr,
    input wire logic [1:0]             htrans,
    input wire logic                   hwrite,
    input wire logic [2:0]             hsize,
    input wire logic [31:0]            hwdata,
    input wire logic                   hready,
    input wire logic [31:0]            hrdata,
    input wire logic                   hreadyout,
    input wire logic                   hresp,
    input wire logic [NUM_CLIENTS-1:0] error_queue_not_empty,
    input wire logic [NUM_CLIENTS-1:0] service_request,
    input wire logic [NUM_CLIENTS-1:0] individual_status_flag
);
    import status_pkg::*;
    logic       wr_srq;
    logic       wr_ppm;
    logic [7:0] srm0;
    logic [7:0] ppm0;
    wire        taken = hsel && hready && htrans[1] && ce
                     && hsize == HSIZE_WORD;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ==========
    // Client zero mask shadows.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_srq <= 1'b0;
            wr_ppm <= 1'b0;
            srm0   <= BYTE_RESET;
            ppm0   <= BYTE_RESET;
        end else begin
            wr_srq <= taken && hwrite && haddr[11:0] == {4'h0, OFF_SRQ_MASK};
            wr_ppm <= taken && hwrite && haddr[11:0] == {4'h0, OFF_POLL_MASK};
            srm0   <= wr_srq ? hwdata[7:0] : srm0;
            ppm0   <= wr_ppm ? hwdata[7:0] : ppm0;
        end
    end
    // ==========
    // Assertions.
    property p_read_wait; taken && !hwrite |=> !hreadyout ##1 hreadyout;
    endproperty
    a_read_wait: assert property (p_read_wait)
        else $error("read wait wrong");
    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay)
        else $error("error response");
    property p_top_zero; $rose(hreadyout) |-> !hrdata[TOP_BIT]; endproperty
    a_top_zero: assert property (p_top_zero)
        else $error("bit 15 set");
    property p_upper_zero; $rose(hreadyout) |-> hrdata[31:16] == 16'h0000;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("upper bits set");
    property p_reset_out; $rose(hresetn) |-> service_request == '0
        && individual_status_flag == '0; endproperty
    a_reset_out: assert property (p_reset_out)
        else $error("reset outputs");
    property p_srq_bit6; srm0 == 8'h40 && $past(srm0) == 8'h40
        |-> !service_request[0]; endproperty
    a_srq_bit6: assert property (p_srq_bit6)
        else $error("bit 6 requested");
    property p_srq_off; srm0 == 8'h00 && $past(srm0) == 8'h00
        |-> !service_request[0]; endproperty
    a_srq_off: assert property (p_srq_off)
        else $error("unmasked request");
    property p_srq_err; $rose(error_queue_not_empty[0]) && srm0 == 8'h04
        |-> ##[1:3] service_request[0]; endproperty
    a_srq_err: assert property (p_srq_err)
        else $error("no error request");
    property p_flag_off; ppm0 == 8'h00 && $past(ppm0) == 8'h00
        |-> !individual_status_flag[0]; endproperty
    a_flag_off: assert property (p_flag_off)
        else $error("flag not gated");
    property p_flag_err; $rose(error_queue_not_empty[0]) && ppm0 == 8'h04
        |-> ##[1:3] individual_status_flag[0]; endproperty
    a_flag_err: assert property (p_flag_err)
        else $error("flag not raised");
endmodule
bind status_reporting_hierarchy status_reporting_hierarchy_monitor #(
    .NUM_CLIENTS(NUM_CLIENTS)) i_status_reporting_hierarchy_monitor (
    .hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .error_queue_not_empty,
    .service_request, .individual_status_flag);

// >>> verif/status_reporting_hierarchy_test.sv
`timescale 1ns/1ps
// ==========
// Self-checking bench.
module status_reporting_hierarchy_test;
    import status_pkg::*;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        sweep = 1'b0;
    logic [15:0] ques_cond = 16'h0000;
    logic [15:0] ext_cond = 16'h0000;
    logic [15:0] std_cond = 16'h0000;
    logic [1:0]  mav = 2'b00;
    logic [1:0]  err = 2'b00;
    logic [1:0]  srq;
    logic [1:0]  flag;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        timed_out;
    int          bad_count = 0;
    int          cmp_count = 0;
    int          srq_count = 0;
    always #20 hclk = ~hclk;
    always @(posedge hclk) if (srq[0] === 1'b1) srq_count <= srq_count + 1;
    host_bus_model i_host_bus_model (.hclk, .hready(hreadyout), .hrdata,
        .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .timed_out);
    status_reporting_hierarchy #(.NUM_CLIENTS(2))
        i_status_reporting_hierarchy (
        .hclk, .hresetn, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp(),
        .sweep_active(sweep), .operation_cond(16'h0000),
        .questionable_cond(ques_cond), .trace_cond(16'h0000),
        .extension_cond(ext_cond), .standard_event_cond(std_cond),
        .message_available(mav), .error_queue_not_empty(err),
        .service_request(srq), .individual_status_flag(flag));
    // ==========
    // Shared tasks.
    task automatic tally_and_finish();
        if (timed_out === 1'b1) bad_count++;
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input int c, logic [7:0] off, logic [31:0] d);
        logic [31:0] unused;
        i_host_bus_model.xfer(1'b1, {20'h0, 4'(c), off}, d, unused);
    endtask
    task automatic rd(input int c, logic [7:0] off, logic [31:0] e);
        logic [31:0] got;
        i_host_bus_model.xfer(1'b0, {20'h0, 4'(c), off}, 32'h0, got);
        if (timed_out === 1'b1) tally_and_finish();
        chk(got, e);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask
    // ==========
    // Scenarios.
    task automatic s_reset_and_map();
        rd(0, {REG_OPERATION, OFF_RISING}, 32'h0);
        rd(0, OFF_STATUS, 32'h0);
        rd(0, 8'hFC, 32'h0);
        wr(0, {REG_QUESTIONABLE, OFF_EVENT}, 32'hFFFF);
        rd(0, {REG_QUESTIONABLE, OFF_EVENT}, 32'h0);
    endtask
    task automatic s_edges();
        wr(0, {REG_QUESTIONABLE, OFF_RISING}, 32'hFFFD);
        wr(0, {REG_QUESTIONABLE, OFF_FALLING}, 32'h0002);
        rd(0, {REG_QUESTIONABLE, OFF_RISING}, 32'h7FFD);
        rd(0, {REG_QUESTIONABLE, OFF_RISING}, 32'h7FFD);
        ques_cond <= 16'h8003;
        cyc(3);
        rd(0, {REG_QUESTIONABLE, OFF_COND}, 32'h0003);
        rd(0, {REG_QUESTIONABLE, OFF_COND}, 32'h0003);
        rd(0, {REG_QUESTIONABLE, OFF_EVENT}, 32'h0001);
        rd(0, {REG_QUESTIONABLE, OFF_EVENT}, 32'h0000);
        ques_cond <= 16'h0000;
        cyc(3);
        rd(0, {REG_QUESTIONABLE, OFF_EVENT}, 32'h0002);
    endtask
    task automatic s_sweep_chain();
        wr(0, {REG_OPERATION, OFF_RISING}, 32'h0008);
        wr(0, OFF_CHAIN, 32'h1);
        wr(0, {REG_EXTENSION, OFF_RISING}, 32'h0001);
        wr(0, {REG_EXTENSION, OFF_MASK}, 32'h0001);
        sweep <= 1'b1;
        ext_cond <= 16'h0001;
        cyc(5);
        rd(0, {REG_OPERATION, OFF_COND}, 32'h4008);
        rd(0, {REG_OPERATION, OFF_EVENT}, 32'h0008);
        rd(0, {REG_OPERATION, OFF_COND}, 32'h0008);
        rd(0, OFF_STATUS, 32'h01);
        rd(0, {REG_EXTENSION, OFF_EVENT}, 32'h0001);
        rd(0, OFF_STATUS, 32'h00);
    endtask
    task automatic s_summary();
        int n;
        wr(0, {REG_QUESTIONABLE, OFF_MASK}, 32'h0001);
        wr(1, {REG_QUESTIONABLE, OFF_MASK}, 32'h0001);
        wr(0, OFF_SRQ_MASK, 32'h08);
        n = srq_count;
        ques_cond <= 16'h0001;
        cyc(4);
        chk(32'(srq_count), 32'(n + 1));
        rd(0, OFF_STATUS, 32'h48);
        rd(1, OFF_STATUS, 32'h00);
        rd(0, {REG_QUESTIONABLE, OFF_EVENT}, 32'h0001);
        rd(0, OFF_STATUS, 32'h00);
        wr(0, OFF_SRQ_MASK, 32'h00);
        wr(0, {REG_STD_EVENT, OFF_RISING}, 32'h0001);
        wr(0, {REG_STD_EVENT, OFF_MASK}, 32'h0001);
        std_cond <= 16'h0001;
        cyc(4);
        rd(0, OFF_STATUS, 32'h20);
        rd(0, {REG_STD_EVENT, OFF_EVENT}, 32'h0001);
    endtask
    task automatic s_err();
        int n;
        wr(0, OFF_SRQ_MASK, 32'h04);
        wr(0, OFF_POLL_MASK, 32'h04);
        n = srq_count;
        err <= 2'b01;
        mav <= 2'b01;
        cyc(4);
        chk(32'(srq_count), 32'(n + 1));
        chk({31'h0, flag[0]}, 32'h1);
        chk({31'h0, flag[1]}, 32'h0);
        rd(0, OFF_STATUS, 32'h54);
        wr(0, OFF_POLL_MASK, 32'h40);
        cyc(3);
        chk({31'h0, flag[0]}, 32'h1);
        wr(0, OFF_SRQ_MASK, 32'h40);
        cyc(3);
        chk({31'h0, flag[0]}, 32'h0);
        chk(32'(srq_count), 32'(n + 1));
    endtask
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        s_reset_and_map();
        s_edges();
        s_sweep_chain();
        s_summary();
        s_err();
        tally_and_finish();
    end
endmodule
